// File: verilog/gzsc_pkg.sv
// Constants and types for the gauge zeroing step and stall logic
// Functional notes
// RULE1 - Delta code selects 0 to 61.440 ms, 4.096 ms steps
// RULE2 - Multiplier codes 00,01,10 scale delta by 1,2,4
// RULE3 - Host avoids multiplier code 11, accumulator overflow
// RULE4 - Nonzero delta: step is delta times multiplier plus blanking
// RULE5 - Zero delta: step is blanking plus 2.048 ms
// RULE6 - Blanking is 512 us cleared, 768 us set
// RULE7 - Reset: multiplier 00, blanking 0, delta 0011
// RULE8 - Blanking starts at coil change, precedes integration
// RULE9 - Integrate back-EMF, result in 15-bit accumulator each step
// RULE10 - Signed result: sign 0 moving, 1 stalled
// RULE11 - Stall ends zeroing and stops stepping
// RULE12 - Integrator and accumulator reinitialised every full step
// RULE13 - Accumulator readout puts sign on output bit 14
// RULE14 - Preload sets start value to minus sixteen PV minus one
// RULE15 - Preload resets to zero, start value minus one
// RULE16 - Host picks preload so stall leaves sign set
// RULE17 - Config register at address 101, write only
// RULE18 - Zeroing moves in full steps, one coil driven
// RULE19 - Enable bit one starts zeroing, zero stops it
// RULE20 - New config applies from next full step boundary
package gzsc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Command addresses
  localparam logic [2:0] ADDR_ZERO_CTRL = 3'h4;
  localparam logic [2:0] ADDR_ZERO_CFG = 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int CFG_W = 13;
  localparam int MULT_LSB = 11;
  localparam int PRELOAD_LSB = 5;
  localparam int BLANK_BIT = 4;
  localparam int DELTA_LSB = 0;
  localparam logic [12:0] CFG_RESET = 13'h0003;
  localparam int CTRL_RES_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_UNCOND_BIT = 4;
  localparam int ACC_W = 15;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: all step times are whole multiples of one 256 us tick
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 256;
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  localparam int BLANK_SHORT_US = 512;
  localparam int BLANK_LONG_US = 768;
  localparam int DELTA_STEP_US = 4096;
  localparam int ZERO_DELTA_US = 2048;
  localparam logic [10:0] BLANK_SHORT_TICKS = 11'(BLANK_SHORT_US / TICK_US);
  localparam logic [10:0] BLANK_LONG_TICKS = 11'(BLANK_LONG_US / TICK_US);
  localparam int DELTA_SHIFT = $clog2(DELTA_STEP_US / TICK_US);
  localparam logic [10:0] ZERO_DELTA_TICKS = 11'(ZERO_DELTA_US / TICK_US);
  localparam int STEP_W = 11;

  ////////////////////////////////////////////////////////////////////////////////
  // Zeroing sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BLANK = 3'b010,
    ST_INTEG = 3'b100
  } gzsc_state_e;

endpackage

// File: verilog/gzsc_step_if.sv
// Handshake between the zeroing sequencer and its step timer
`timescale 1ns/100ps
interface gzsc_step_if;
  logic start;
  logic stop;
  logic [10:0] blank_ticks;
  logic [10:0] step_ticks;
  logic blank_end;
  logic step_end;
  modport timer (input start, stop, blank_ticks, step_ticks, output blank_end, step_end);
  modport ctrl (output start, stop, blank_ticks, step_ticks, input blank_end, step_end);
endinterface

// File: verilog/gzsc_step_timer.sv
// Full step timer: tick divider plus blanking and step length counters
`timescale 1ns/100ps
module gzsc_step_timer #(
  parameter int unsigned TICK_CYCLES = gzsc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sequencer side
  gzsc_step_if.timer step
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  logic active_q, active_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [10:0] ticks_q, ticks_d;
  logic [10:0] blank_len_q, blank_len_d;
  logic [10:0] step_len_q, step_len_d;
  logic tick;
  logic [10:0] ticks_inc;
  logic [31:0] cyc_q, cyc_d;

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle tick every 256 us while a step runs
  assign tick = active_q && (div_q == DIV_W'(TICK_CYCLES - 1));
  assign ticks_inc = ticks_q + 11'h001;
  // Edge pulses are combinational so the next step starts without a gap
  assign step.blank_end = tick && !step.stop && (ticks_inc == blank_len_q); // see RULE8
  assign step.step_end = tick && !step.stop && (ticks_inc == step_len_q); // see RULE4

  // Next state: lengths latched at start, so later writes wait a step
  always_comb begin
    active_d = active_q;
    div_d = div_q;
    ticks_d = ticks_q;
    blank_len_d = blank_len_q;
    step_len_d = step_len_q;
    cyc_d = active_q ? cyc_q + 32'h1 : cyc_q;
    if (step.start) begin
      active_d = 1'b1; // see RULE20
      div_d = '0;
      ticks_d = '0;
      blank_len_d = step.blank_ticks;
      step_len_d = step.step_ticks;
      cyc_d = 32'h1;
    end else if (step.stop) begin
      active_d = 1'b0;
    end else if (tick) begin
      div_d = '0;
      ticks_d = ticks_inc;
      if (step.step_end) begin
        active_d = 1'b0;
      end
    end else if (active_q) begin
      div_d = div_q + DIV_W'(1);
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b0;
      div_q <= '0;
      ticks_q <= '0;
      blank_len_q <= '0;
      step_len_q <= '0;
      cyc_q <= '0;
    end else begin
      active_q <= active_d;
      div_q <= div_d;
      ticks_q <= ticks_d;
      blank_len_q <= blank_len_d;
      step_len_q <= step_len_d;
      cyc_q <= cyc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on step and blanking length in clock cycles
  a_step_len_cycles: assert property (@(posedge clk) disable iff (!rst_b) // see RULE4
    step.step_end |-> cyc_q == 32'(step_len_q) * 32'(TICK_CYCLES))
    else $error("full step length wrong");
  a_blank_len_cycles: assert property (@(posedge clk) disable iff (!rst_b) // see RULE6
    step.blank_end |-> cyc_q == 32'(blank_len_q) * 32'(TICK_CYCLES))
    else $error("blanking length wrong");

endmodule

// File: verilog/gzsc_zeroing.sv
// Zeroing sequencer: config register, coil stepping, back-EMF integrator, stall stop
`timescale 1ns/100ps
module gzsc_zeroing #(
  parameter int unsigned TICK_CYCLES = gzsc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Decoded serial command
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_addr,
  input wire logic [12:0] cmd_data,
  // Status output selection
  input wire logic acc_readout_sel,
  // Sigma-delta bit stream from the open coil
  input wire logic bemf_valid,
  input wire logic bemf_bit,
  // Coil drive
  output logic coil_a_drive,
  output logic coil_b_drive,
  output logic coil_negative,
  // Status
  output logic zeroing_active,
  output logic zero_found,
  output logic serial_out_bit_14,
  output logic [14:0] acc_result
);

  gzsc_step_if step_bus ();

  gzsc_pkg::gzsc_state_e st_q, st_d;
  logic [12:0] cfg_q, cfg_d;
  logic dir_q, dir_d;
  logic uncond_q, uncond_d;
  logic [1:0] phase_q, phase_d;
  logic [14:0] acc_run_q, acc_run_d;
  logic [14:0] acc_res_q, acc_res_d;
  logic coil_a_q, coil_a_d;
  logic coil_b_q, coil_b_d;
  logic coil_neg_q, coil_neg_d;
  logic found_q, found_d;
  logic bit14_q, bit14_d;
  logic start_req, stop_req, cfg_wr;
  logic [1:0] mult;
  logic [5:0] preload_code;
  logic [3:0] delta;
  logic [10:0] blank_len;
  logic [10:0] delta_len;
  logic [14:0] preload_val;
  logic [14:0] acc_next;
  logic stalled;
  logic cfg_written_q;
  logic [14:0] chk_sum_q, chk_sum_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode: enable needs the reserved bit at zero
  assign cfg_wr = cmd_valid && (cmd_addr == gzsc_pkg::ADDR_ZERO_CFG); // see RULE17
  assign start_req = cmd_valid && (cmd_addr == gzsc_pkg::ADDR_ZERO_CTRL)
    && !cmd_data[gzsc_pkg::CTRL_RES_BIT] && cmd_data[gzsc_pkg::CTRL_EN_BIT]; // see RULE19
  assign stop_req = cmd_valid && (cmd_addr == gzsc_pkg::ADDR_ZERO_CTRL)
    && !cmd_data[gzsc_pkg::CTRL_RES_BIT] && !cmd_data[gzsc_pkg::CTRL_EN_BIT]; // see RULE19

  ////////////////////////////////////////////////////////////////////////////////
  // Step length in ticks from the current configuration
  assign mult = cfg_q[gzsc_pkg::MULT_LSB +: 2];
  assign preload_code = cfg_q[gzsc_pkg::PRELOAD_LSB +: 6];
  assign delta = cfg_q[gzsc_pkg::DELTA_LSB +: 4];
  assign blank_len = cfg_q[gzsc_pkg::BLANK_BIT] ? gzsc_pkg::BLANK_LONG_TICKS
    : gzsc_pkg::BLANK_SHORT_TICKS; // see RULE6
  // Code 11 gives x8, kept as the hardware does it
  assign delta_len = (11'(delta) << gzsc_pkg::DELTA_SHIFT) << mult; // see RULE1, see RULE2
  assign step_bus.blank_ticks = blank_len;
  assign step_bus.step_ticks = (delta == 4'h0) ? blank_len + gzsc_pkg::ZERO_DELTA_TICKS // see RULE5
    : blank_len + delta_len; // see RULE4
  // Minus sixteen PV minus one is the inverse of sixteen PV
  assign preload_val = ~{5'h00, preload_code, 4'h0}; // see RULE14
  // Sigma-delta sample adds one or subtracts one; wraps like the hardware
  assign acc_next = acc_run_q + {{14{~bemf_bit}}, 1'b1}; // see RULE9
  assign stalled = acc_run_q[gzsc_pkg::ACC_W-1]; // see RULE10

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    st_d = st_q;
    cfg_d = cfg_wr ? cmd_data : cfg_q;
    dir_d = start_req ? cmd_data[gzsc_pkg::CTRL_DIR_BIT] : dir_q;
    uncond_d = start_req ? cmd_data[gzsc_pkg::CTRL_UNCOND_BIT] : uncond_q;
    phase_d = phase_q;
    acc_run_d = acc_run_q;
    acc_res_d = acc_res_q;
    found_d = 1'b0;
    step_bus.start = 1'b0;
    step_bus.stop = 1'b0;
    case (st_q)
      gzsc_pkg::ST_IDLE: begin
        if (start_req) begin
          st_d = gzsc_pkg::ST_BLANK;
        end
      end
      gzsc_pkg::ST_BLANK: begin
        if (stop_req) begin
          st_d = gzsc_pkg::ST_IDLE;
          step_bus.stop = 1'b1;
        end else if (step_bus.blank_end) begin
          st_d = gzsc_pkg::ST_INTEG; // see RULE8
        end
      end
      gzsc_pkg::ST_INTEG: begin
        if (bemf_valid) begin
          acc_run_d = acc_next; // see RULE9
        end
        if (stop_req) begin
          st_d = gzsc_pkg::ST_IDLE;
          step_bus.stop = 1'b1;
        end else if (step_bus.step_end) begin
          acc_res_d = acc_run_q; // see RULE9
          if (stalled && !uncond_q) begin
            st_d = gzsc_pkg::ST_IDLE; // see RULE11
            found_d = 1'b1;
          end else begin
            st_d = gzsc_pkg::ST_BLANK;
          end
        end
      end
      default: begin
        st_d = gzsc_pkg::ST_IDLE;
      end
    endcase
    // Every step begins with a coil change, a fresh preload and new timing
    if (st_d == gzsc_pkg::ST_BLANK && st_q != gzsc_pkg::ST_BLANK) begin
      step_bus.start = 1'b1; // see RULE20
      acc_run_d = preload_val; // see RULE12, see RULE14
      phase_d = dir_d ? phase_q + 2'h1 : phase_q - 2'h1;
    end
    // One coil driven while zeroing, none in idle; even phases coil A, odd phases coil B
    coil_a_d = (st_d != gzsc_pkg::ST_IDLE) && !phase_d[0]; // see RULE18
    coil_b_d = (st_d != gzsc_pkg::ST_IDLE) && phase_d[0]; // see RULE18
    coil_neg_d = phase_d[1];
    bit14_d = acc_readout_sel && acc_res_d[gzsc_pkg::ACC_W-1]; // see RULE13
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= gzsc_pkg::ST_IDLE;
      cfg_q <= gzsc_pkg::CFG_RESET; // see RULE7, see RULE15
      dir_q <= 1'b0;
      uncond_q <= 1'b0;
      phase_q <= 2'h0;
      acc_run_q <= '1;
      acc_res_q <= '1;
      coil_a_q <= 1'b0;
      coil_b_q <= 1'b0;
      coil_neg_q <= 1'b0;
      found_q <= 1'b0;
      bit14_q <= 1'b0;
      cfg_written_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      dir_q <= dir_d;
      uncond_q <= uncond_d;
      phase_q <= phase_d;
      acc_run_q <= acc_run_d;
      acc_res_q <= acc_res_d;
      coil_a_q <= coil_a_d;
      coil_b_q <= coil_b_d;
      coil_neg_q <= coil_neg_d;
      found_q <= found_d;
      bit14_q <= bit14_d;
      cfg_written_q <= cfg_written_q || cfg_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Step timer
  gzsc_step_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .step(step_bus)
  );

  // Outputs
  assign coil_a_drive = coil_a_q;
  assign coil_b_drive = coil_b_q;
  assign coil_negative = coil_neg_q;
  assign zeroing_active = (st_q != gzsc_pkg::ST_IDLE);
  assign zero_found = found_q;
  assign serial_out_bit_14 = bit14_q;
  assign acc_result = acc_res_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Check model of the accumulator, kept apart from the datapath above
  // It counts accepted samples from the step's own start value, so a missed
  // reload or a sample taken in blanking shows up as a wrong result

  // Next model value: reload at each step start, count samples while integrating
  always_comb begin
    chk_sum_d = chk_sum_q;
    if (step_bus.start) begin
      chk_sum_d = 15'h7fff - (15'(preload_code) << 4); // Minus sixteen PV minus one
    end else if (st_q == gzsc_pkg::ST_INTEG && bemf_valid) begin
      chk_sum_d = bemf_bit ? chk_sum_q + 15'h0001 : chk_sum_q - 15'h0001;
    end
  end

  // Model register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_sum_q <= 15'h7fff;
    end else begin
      chk_sum_q <= chk_sum_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_one_coil_only: assert property (!(coil_a_q && coil_b_q)) // see RULE18
    else $error("both coils driven");
  a_cfg_reset_val: assert property (!cfg_written_q |-> cfg_q == 13'h0003 // see RULE7
    && step_bus.step_ticks == 11'h032 && preload_val == 15'h7fff)
    else $error("reset config wrong");
  a_cfg_write_lands: assert property (cfg_wr |=> cfg_q == $past(cmd_data)) // see RULE17
    else $error("config write lost");
  a_start_zeroing: assert property (st_q == gzsc_pkg::ST_IDLE && start_req // see RULE19
    |=> st_q == gzsc_pkg::ST_BLANK && (coil_a_q ^ coil_b_q))
    else $error("zeroing did not start");
  a_stop_zeroing: assert property (st_q != gzsc_pkg::ST_IDLE && stop_req // see RULE19
    |=> st_q == gzsc_pkg::ST_IDLE && !coil_a_q && !coil_b_q)
    else $error("zeroing did not stop");
  a_stall_stop: assert property (st_q == gzsc_pkg::ST_INTEG && step_bus.step_end // see RULE11
    && !stop_req && stalled && !uncond_q |=> zero_found && !zeroing_active
    ##1 !zero_found)
    else $error("stall did not end zeroing");
  a_step_reinit: assert property (st_q == gzsc_pkg::ST_INTEG && step_bus.step_end // see RULE12
    && !stop_req && (!stalled || uncond_q) |=> st_q == gzsc_pkg::ST_BLANK
    && acc_run_q == ~{5'h00, $past(preload_code), 4'h0} && phase_q != $past(phase_q))
    else $error("step not reinitialised");
  a_blank_first: assert property (st_q == gzsc_pkg::ST_BLANK && bemf_valid // see RULE8
    |=> acc_run_q == $past(acc_run_q))
    else $error("integration during blanking");
  a_blank_in_state: assert property (step_bus.blank_end // see RULE8
    |-> st_q == gzsc_pkg::ST_BLANK)
    else $error("blanking ended outside blanking");
  a_result_bit14: assert property (st_q == gzsc_pkg::ST_INTEG && step_bus.step_end // see RULE13
    && !stop_req |=> serial_out_bit_14 == ($past(acc_readout_sel) && acc_result[14]))
    else $error("bit 14 not accumulator sign");

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulator, stall and step checks
  // The result is held between step ends and matches the check model
  a_acc_model: assert property (st_q == gzsc_pkg::ST_INTEG && step_bus.step_end // see RULE9
    && !stop_req |=> acc_result == $past(chk_sum_q))
    else $error("accumulator result wrong");
  a_result_hold: assert property (!(st_q == gzsc_pkg::ST_INTEG && step_bus.step_end // see RULE9
    && !stop_req) |=> acc_result == $past(acc_result))
    else $error("accumulator result changed mid step");
  a_found_pulse: assert property (zero_found // see RULE11
    |-> !zeroing_active ##1 !zero_found)
    else $error("stall flag held");
  a_uncond_runs: assert property (st_q == gzsc_pkg::ST_INTEG && step_bus.step_end // see RULE11
    && !stop_req && uncond_q |=> zeroing_active && !zero_found)
    else $error("unconditional zeroing stopped");
  a_step_ticks: assert property (step_bus.step_ticks // see RULE4, see RULE5
    == (cfg_q[gzsc_pkg::BLANK_BIT] ? 11'h003 : 11'h002)
    + ((delta == 4'h0) ? 11'h008 : (11'(delta) << (4 + mult))))
    else $error("step length decode wrong");
  a_coil_change: assert property (step_bus.start && st_q != gzsc_pkg::ST_IDLE // see RULE8
    |=> coil_a_drive != $past(coil_a_drive))
    else $error("coil did not change at step");
  a_coil_active: assert property (zeroing_active // see RULE18
    == (coil_a_drive ^ coil_b_drive))
    else $error("coil drive not matching zeroing");

  ////////////////////////////////////////////////////////////////////////////////
  // Command handling checks
  a_cfg_hold: assert property (!cfg_wr |=> cfg_q == $past(cfg_q)) // see RULE17
    else $error("config changed without a write");
  a_start_running: assert property (st_q == gzsc_pkg::ST_BLANK && start_req // see RULE19
    |=> st_q != gzsc_pkg::ST_IDLE)
    else $error("repeated start stopped zeroing");
  a_stop_quiet: assert property (st_q != gzsc_pkg::ST_IDLE && stop_req // see RULE19
    |=> !zero_found)
    else $error("stop reported a stall");

  ////////////////////////////////////////////////////////////////////////////////
  // Covers of the main scenarios
  c_stall_found: cover property (zero_found);
  c_step_repeat: cover property (st_q == gzsc_pkg::ST_INTEG ##1 st_q == gzsc_pkg::ST_BLANK);
  c_host_stop: cover property (st_q == gzsc_pkg::ST_INTEG && stop_req);
  c_uncond_stall: cover property (st_q == gzsc_pkg::ST_INTEG && step_bus.step_end && stalled
    && uncond_q);
  c_long_blank: cover property (step_bus.blank_end && cfg_q[gzsc_pkg::BLANK_BIT]);

endmodule

// File: test/gzsc_host_model.sv
// Host model: issues decoded zeroing commands to the block
`timescale 1ns/100ps
module gzsc_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic [2:0] cmd_addr,
  output logic [12:0] cmd_data
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle command port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_addr = 3'h0;
    cmd_data = 13'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle command pulse, launched just after a rising edge
  // Multiplier code 11 is never sent in a config word
  // Preloads are chosen so a stalled step ends with the sign set
  // Address 101 is only written, nothing is read back
  task automatic send(input logic [2:0] addr, input logic [12:0] data);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_addr = addr;
    cmd_data = data;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_addr = ~addr; // Stale values must not be relied upon
    cmd_data = ~data;
  endtask
endmodule

// File: test/gzsc_zeroing_step_and_stall_config_tb_top.sv
// Self-checking testbench for the zeroing step and stall logic
`timescale 1ns/100ps
module gzsc_zeroing_step_and_stall_config_tb_top;
  localparam int T = 4;
  localparam logic [12:0] CFG_TAB [5] = '{13'h0000, 13'h1010, 13'h0831, 13'h17ef, 13'h0042};
  localparam int LEN_TAB [5] = '{10, 11, 35, 962, 34};
  localparam logic [14:0] ACC_TAB [5] = '{15'h7fff, 15'h7fff, 15'h7fef, 15'h7c0f, 15'h7fdf};
  logic clk = 1'b0;
  logic rst_b;
  logic acc_readout_sel;
  logic bemf_valid;
  logic bemf_bit;
  logic cmd_valid;
  logic [2:0] cmd_addr;
  logic [12:0] cmd_data;
  logic coil_a_drive;
  logic coil_b_drive;
  logic coil_negative;
  logic zeroing_active;
  logic zero_found;
  logic serial_out_bit_14;
  logic [14:0] acc_result;
  int n_fail = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, host model and block
  always #12.5 clk = ~clk;
  gzsc_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data));
  gzsc_zeroing #(.TICK_CYCLES(T)) uut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .acc_readout_sel(acc_readout_sel),
    .bemf_valid(bemf_valid), .bemf_bit(bemf_bit), .coil_a_drive(coil_a_drive),
    .coil_b_drive(coil_b_drive), .coil_negative(coil_negative),
    .zeroing_active(zeroing_active), .zero_found(zero_found),
    .serial_out_bit_14(serial_out_bit_14), .acc_result(acc_result));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bounded wait
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Count edges until coil A drives (coil=1) or a stall pulse shows (coil=0)
  task automatic wait_evt(input bit coil, inout int n);
    while ((coil ? coil_a_drive : zero_found) !== 1'b1 && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 6000) begin
      n_fail++;
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One stalled step with no back-EMF: checks length, preload and readout bit
  task automatic run_step(input bit wr, input logic [12:0] cfg, input int len,
                          input logic [14:0] acc);
    int n;
    n = 0;
    if (wr) begin
      host.send(gzsc_pkg::ADDR_ZERO_CFG, cfg);
    end
    host.send(3'h3, 13'h1fff); // Other address leaves config alone
    host.send(gzsc_pkg::ADDR_ZERO_CTRL, 13'h0002);
    wait_evt(1'b0, n);
    check(15'(n), 15'(len * T));
    check(acc_result, acc);
    check(15'(zeroing_active), 15'h0000);
    @(posedge clk);
    #1;
    check(15'(serial_out_bit_14), 15'(acc_readout_sel));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Moving step, mid-step config write, then a stall on the following step
  task automatic moving_then_stall();
    int n;
    host.send(gzsc_pkg::ADDR_ZERO_CFG, 13'h0003);
    bemf_valid = 1'b1;
    bemf_bit = 1'b1;
    host.send(gzsc_pkg::ADDR_ZERO_CTRL, 13'h0002);
    @(posedge clk);
    #1;
    check(15'(zeroing_active), 15'h0001);
    check(15'({coil_a_drive, coil_b_drive}), 15'h0001);
    host.send(gzsc_pkg::ADDR_ZERO_CFG, 13'h0001);
    n = 3;
    wait_evt(1'b1, n);
    check(15'(n), 15'(50 * T)); // Current step keeps its length
    check(15'(coil_b_drive), 15'h0000);
    check(15'(acc_result[14]), 15'h0000);
    check(15'(zeroing_active), 15'h0001);
    bemf_bit = 1'b0;
    wait_evt(1'b0, n);
    check(15'(n), 15'((50 + 18) * T)); // Next step takes its length from the new config
    check(15'(acc_result[14]), 15'h0001);
    bemf_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reserved bit set is ignored; unconditional start rides over a stall; repeat start; stop
  task automatic stop_and_ignore();
    host.send(gzsc_pkg::ADDR_ZERO_CTRL, 13'h0003);
    @(posedge clk);
    #1;
    check(15'(zeroing_active), 15'h0000);
    host.send(gzsc_pkg::ADDR_ZERO_CTRL, 13'h0016);
    @(posedge clk);
    #1;
    check(15'(zeroing_active), 15'h0001);
    check(15'({coil_a_drive, coil_b_drive, coil_negative}), 15'h0002); // B+
    repeat (18 * T) @(posedge clk);
    #1;
    check(15'(zeroing_active), 15'h0001); // Unconditional keeps going
    check(acc_result, 15'h7fff); // Fresh preload per step
    check(15'({coil_a_drive, coil_b_drive, coil_negative}), 15'h0005); // A
    host.send(gzsc_pkg::ADDR_ZERO_CTRL, 13'h0016);
    @(posedge clk);
    #1;
    check(15'(zeroing_active), 15'h0001); // Repeated start ignored
    host.send(gzsc_pkg::ADDR_ZERO_CTRL, 13'h0000);
    @(posedge clk);
    #1;
    check(15'({zeroing_active, coil_a_drive, coil_b_drive}), 15'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    acc_readout_sel = 1'b0;
    bemf_valid = 1'b0;
    bemf_bit = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check(acc_result, 15'h7fff);
    run_step(1'b0, 13'h0003, 50, 15'h7fff); // Reset config
    // Delta zero, both blankings, multipliers 00/01/10, preload edges
    for (int i = 0; i < 5; i++) begin
      acc_readout_sel = i[0];
      run_step(1'b1, CFG_TAB[i], LEN_TAB[i], ACC_TAB[i]);
    end
    acc_readout_sel = 1'b0;
    moving_then_stall();
    stop_and_ignore();
    results();
  end
endmodule
